// ==== hdl/ar_pkg.sv ====
package ar_pkg;

    localparam int NARROW_W   = 16;
    localparam int WIDE_W     = 24;
    localparam int STORE_W    = 32;
    localparam int IMM_W      = 7;
    localparam int STACK_STEP = 4;

    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;

    localparam logic [23:0] SP_RESET    = 24'h000000;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;
    localparam logic [23:0] STEP_24     = 24'h000004;

    typedef enum logic [3:0] {
        AR_OP_ADD   = 4'h0,
        AR_OP_ADD_A = 4'h1,
        AR_OP_ADC   = 4'h2,
        AR_OP_SUB   = 4'h3,
        AR_OP_SUB_A = 4'h4,
        AR_OP_SBC   = 4'h5,
        AR_OP_CMP   = 4'h6,
        AR_OP_CMP_A = 4'h7,
        AR_OP_CMC   = 4'h8,
        AR_OP_STORE = 4'h9,
        AR_OP_LD_SP = 4'ha
    } ar_op_type;

    typedef enum logic [1:0] {
        AR_SRC_REG  = 2'h0,
        AR_SRC_UIMM = 2'h1,
        AR_SRC_SIMM = 2'h2
    } ar_src_type;

    typedef enum logic [0:0] {
        AR_DST_REG = 1'h0,
        AR_DST_SP  = 1'h1
    } ar_dst_type;

    typedef enum logic [1:0] {
        AR_COND_ALWAYS = 2'h0,
        AR_COND_C      = 2'h1,
        AR_COND_NC     = 2'h2
    } ar_cond_type;

    typedef enum logic [1:0] {
        AR_STK_PLAIN    = 2'h0,
        AR_STK_POST_INC = 2'h1,
        AR_STK_POST_DEC = 2'h2,
        AR_STK_PRE_DEC  = 2'h3
    } ar_stk_type;

    typedef struct packed {
        logic [23:0] sp;
        logic [3:0]  flags;
        logic        done;
        logic        skipped;
        logic        err;
        logic        wr_en;
        logic [23:0] wr_data;
        logic        st_valid;
        logic [23:0] st_addr;
        logic [31:0] st_data;
    } ar_state_type;

    localparam ar_state_type STATE_RESET = '{
        sp:       SP_RESET,
        flags:    FLAGS_RESET,
        done:     1'b0,
        skipped:  1'b0,
        err:      1'b0,
        wr_en:    1'b0,
        wr_data:  24'h000000,
        st_valid: 1'b0,
        st_addr:  24'h000000,
        st_data:  32'h00000000
    };

endpackage : ar_pkg

// ==== hdl/ar_alu_if.sv ====
`timescale 1ns/10ps
interface ar_alu_if;
    logic [23:0] a;
    logic [23:0] b;
    logic        cin;
    logic        sub;
    logic        wide;
    logic [23:0] res;
    logic [3:0]  flags;

    modport alu (
        input  a,
        input  b,
        input  cin,
        input  sub,
        input  wide,
        output res,
        output flags
    );

    modport user (
        output a,
        output b,
        output cin,
        output sub,
        output wide,
        input  res,
        input  flags
    );
endinterface : ar_alu_if

// ==== hdl/ar_alu.sv ====
`timescale 1ns/10ps
module ar_alu
    import ar_pkg::*;
(
    ar_alu_if.alu p
);
    logic [23:0] a_m;
    logic [23:0] b_m;
    logic [24:0] full;
    logic        msb_a;
    logic        msb_b;
    logic        msb_r;

    // narrow operations see only the low 16 bits
    assign a_m = p.wide ? p.a : {8'h00, p.a[15:0]};
    assign b_m = p.wide ? p.b : {8'h00, p.b[15:0]};

    // carry in acts as borrow when subtracting
    assign full = p.sub
        ? ({1'b0, a_m} - {1'b0, b_m} - {24'h000000, p.cin})
        : ({1'b0, a_m} + {1'b0, b_m} + {24'h000000, p.cin});

    assign msb_a = p.wide ? a_m[WIDE_W-1] : a_m[NARROW_W-1];
    assign msb_b = p.wide ? b_m[WIDE_W-1] : b_m[NARROW_W-1];
    assign msb_r = p.wide ? full[WIDE_W-1] : full[NARROW_W-1];

    assign p.res = p.wide ? full[23:0] : {8'h00, full[15:0]};

    // flags taken at operation width
    assign p.flags[FLAG_N] = msb_r;
    assign p.flags[FLAG_Z] = p.wide ? (full[23:0] == 24'h000000)
                                    : (full[15:0] == 16'h0000);
    assign p.flags[FLAG_V] = p.sub ? ((msb_a != msb_b) && (msb_r != msb_a))
                                   : ((msb_a == msb_b) && (msb_r != msb_a));
    assign p.flags[FLAG_C] = p.wide ? full[WIDE_W] : full[NARROW_W];
endmodule : ar_alu

// ==== hdl/ar_datapath.sv ====
`timescale 1ns/10ps
// Behaviour
// - stack store: post-inc, post-dec, pre-dec
// - add: two registers, 16-bit sum
// - /c runs on C=1, /nc on C=0, register-register forms only
// - add accepts unsigned short immediate, 16-bit
// - wide add: two registers, 24-bit
// - wide add register into stack pointer
// - wide add immediate to register or SP
// - add with carry, two registers, 16-bit
// - add with carry, immediate form
// - subtract register or immediate, 16-bit
// - wide subtract register or immediate
// - wide subtract from stack pointer
// - subtract with borrow, registers, 16-bit
// - subtract with borrow, immediate form
// - compare registers, no destination write
// - compare with sign-extended short immediate
// - wide compare, register or immediate
// - compare with carry as borrow
// - unsigned immediates zero-extended to width
// - stack store zero-extends to 32 bits
module ar_datapath
    import ar_pkg::*;
#(
    parameter int STEP = STACK_STEP
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        op_valid,
    output logic             op_ready,
    input  wire ar_op_type   op_code,
    input  wire ar_src_type  op_src,
    input  wire ar_dst_type  op_dst,
    input  wire ar_cond_type op_cond,
    input  wire ar_stk_type  op_stk,
    input  wire logic [23:0] rd_data,
    input  wire logic [23:0] rs_data,
    input  wire logic [6:0]  op_imm,
    output logic             res_done,
    output logic             res_skipped,
    output logic             res_error,
    output logic             rd_wr_en,
    output logic [23:0]      rd_wr_data,
    output logic [23:0]      sp_value,
    output logic [3:0]       flags,
    output logic             st_valid,
    output logic [23:0]      st_addr,
    output logic [31:0]      st_data
);

    // refuse settings the datapath cannot serve
    if (STEP < 1 || STEP > 255) begin : g_bad_step
        $error("ar_datapath: STEP out of range");
    end
    if (NARROW_W != 16 || WIDE_W != 24) begin : g_bad_width
        $error("ar_datapath: operand widths must be 16 and 24");
    end
    if (STORE_W != 32 || IMM_W != 7) begin : g_bad_imm
        $error("ar_datapath: store or immediate width unsupported");
    end

    localparam logic [23:0] STEP_V = STEP[23:0];

    function automatic logic is_wide(input ar_op_type op);
        return op == AR_OP_ADD_A || op == AR_OP_SUB_A || op == AR_OP_CMP_A;
    endfunction : is_wide

    function automatic logic is_sub(input ar_op_type op);
        return op == AR_OP_SUB || op == AR_OP_SUB_A || op == AR_OP_SBC
            || op == AR_OP_CMP || op == AR_OP_CMP_A || op == AR_OP_CMC;
    endfunction : is_sub

    function automatic logic is_cmp(input ar_op_type op);
        return op == AR_OP_CMP || op == AR_OP_CMP_A || op == AR_OP_CMC;
    endfunction : is_cmp

    function automatic logic uses_carry(input ar_op_type op);
        return op == AR_OP_ADC || op == AR_OP_SBC || op == AR_OP_CMC;
    endfunction : uses_carry

    function automatic logic is_arith(input ar_op_type op);
        return op != AR_OP_STORE && op != AR_OP_LD_SP;
    endfunction : is_arith

    // carry test of the carry-true and carry-false forms
    function automatic logic cond_met(
        input ar_cond_type cond,
        input logic        carry
    );
        unique case (cond)
            AR_COND_ALWAYS: return 1'b1;
            AR_COND_C:      return carry;
            AR_COND_NC:     return ~carry;
            default:        return 1'b1;
        endcase
    endfunction : cond_met

    // only wide add/sub may target the stack pointer
    function automatic logic dst_allowed(
        input ar_op_type  op,
        input ar_dst_type dst
    );
        return dst == AR_DST_REG || op == AR_OP_ADD_A || op == AR_OP_SUB_A;
    endfunction : dst_allowed

    // a pre-decrement store writes below the old pointer
    function automatic logic [23:0] stack_addr(
        input ar_stk_type  mode,
        input logic [23:0] sp
    );
        return (mode == AR_STK_PRE_DEC) ? sp - STEP_V : sp;
    endfunction : stack_addr

    // stack pointer after a store in each mode
    function automatic logic [23:0] stack_next(
        input ar_stk_type  mode,
        input logic [23:0] sp
    );
        logic [23:0] nsp;
        nsp = sp;
        unique case (mode)
            AR_STK_PLAIN:    nsp = sp;
            AR_STK_POST_INC: nsp = sp + STEP_V;
            AR_STK_POST_DEC: nsp = sp - STEP_V;
            AR_STK_PRE_DEC:  nsp = sp - STEP_V;
        endcase
        return nsp;
    endfunction : stack_next

    ar_state_type cur;
    ar_state_type next_cur;
    ar_alu_if     alu_bus ();
    logic [23:0]  opnd_b;
    logic [23:0]  opnd_a;
    logic [23:0]  imm_zx;
    logic [23:0]  imm_sx;
    logic         cond_ok;
    logic         dst_ok;

    ar_alu u_alu (
        .p (alu_bus)
    );

    // immediate extension
    assign imm_zx = {17'h00000, op_imm};
    assign imm_sx = {{17{op_imm[IMM_W-1]}}, op_imm};

    always_comb begin
        unique case (op_src)
            AR_SRC_REG:  opnd_b = rs_data;
            AR_SRC_UIMM: opnd_b = imm_zx;
            AR_SRC_SIMM: opnd_b = imm_sx;
            default:     opnd_b = rs_data;
        endcase
    end

    // stack pointer as left operand for wide add/sub
    assign opnd_a = (op_dst == AR_DST_SP) ? cur.sp : rd_data;

    assign alu_bus.a    = opnd_a;
    assign alu_bus.b    = opnd_b;
    assign alu_bus.sub  = is_sub(op_code);
    assign alu_bus.wide = is_wide(op_code);
    assign alu_bus.cin  = uses_carry(op_code)
                        & cur.flags[FLAG_C];

    // condition only on register-register forms
    always_comb begin
        cond_ok = 1'b1;
        if (op_src == AR_SRC_REG && op_dst == AR_DST_REG
                && is_arith(op_code)) begin
            cond_ok = cond_met(op_cond, cur.flags[FLAG_C]);
        end
    end

    assign dst_ok = dst_allowed(op_code, op_dst);

    assign op_ready = ce;

    always_comb begin
        next_cur          = cur;
        next_cur.done     = 1'b0;
        next_cur.skipped  = 1'b0;
        next_cur.err      = 1'b0;
        next_cur.wr_en    = 1'b0;
        next_cur.st_valid = 1'b0;
        if (op_valid) begin
            next_cur.done = 1'b1;
            if (!cond_ok) begin
                next_cur.skipped = 1'b1;
            end else begin
                unique case (op_code)
                    AR_OP_STORE: begin
                        next_cur.st_valid = 1'b1;
                        next_cur.st_data  = {8'h00, rs_data};
                        next_cur.st_addr  = stack_addr(op_stk, cur.sp);
                        next_cur.sp = stack_next(op_stk, cur.sp);
                    end
                    AR_OP_LD_SP: begin
                        if (op_src == AR_SRC_REG) begin
                            next_cur.sp = rs_data;
                        end else begin
                            next_cur.sp = imm_zx;
                        end
                    end
                    AR_OP_ADD, AR_OP_ADC, AR_OP_SUB, AR_OP_SBC,
                    AR_OP_ADD_A, AR_OP_SUB_A,
                    AR_OP_CMP, AR_OP_CMP_A, AR_OP_CMC: begin
                        if (!dst_ok) begin
                            next_cur.err = 1'b1;
                        end else begin
                            next_cur.flags = alu_bus.flags;
                            if (is_cmp(op_code)) begin
                                next_cur.wr_en = 1'b0;
                            end else if (op_dst == AR_DST_SP) begin
                                next_cur.sp = alu_bus.res;
                            end else begin
                                next_cur.wr_en   = 1'b1;
                                next_cur.wr_data = alu_bus.res;
                            end
                        end
                    end
                    default: begin
                        next_cur.err = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= STATE_RESET;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign res_done    = cur.done;
    assign res_skipped = cur.skipped;
    assign res_error   = cur.err;
    assign rd_wr_en    = cur.wr_en;
    assign rd_wr_data  = cur.wr_data;
    assign sp_value    = cur.sp;
    assign flags       = cur.flags;
    assign st_valid    = cur.st_valid;
    assign st_addr     = cur.st_addr;
    assign st_data     = cur.st_data;

endmodule : ar_datapath

// ==== test/ar_datapath_checker.sv ====
`timescale 1ns/10ps
module ar_datapath_checker
    import ar_pkg::*;
#(
    parameter int STEP = STACK_STEP
)
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        op_valid,
    input wire logic        op_ready,
    input wire ar_op_type   op_code,
    input wire ar_src_type  op_src,
    input wire ar_dst_type  op_dst,
    input wire ar_cond_type op_cond,
    input wire ar_stk_type  op_stk,
    input wire logic [23:0] rd_data,
    input wire logic [23:0] rs_data,
    input wire logic        res_done,
    input wire logic        res_skipped,
    input wire logic        rd_wr_en,
    input wire logic [23:0] rd_wr_data,
    input wire logic [23:0] sp_value,
    input wire logic [3:0]  flags,
    input wire logic        st_valid,
    input wire logic [23:0] st_addr,
    input wire logic [31:0] st_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] sum16;
    logic [23:0] sum24;
    logic [23:0] sp_sum;
    assign sum16 = rd_data[15:0] + rs_data[15:0];
    assign sum24 = rd_data + rs_data;
    assign sp_sum = sp_value + rs_data;
    sequence s_take;
        ce && op_valid;
    endsequence
    sequence s_rr(o);
        s_take ##0 (op_code == o && op_src == AR_SRC_REG
                    && op_dst == AR_DST_REG && op_cond == AR_COND_ALWAYS);
    endsequence
    chk_ready_ce: assert property (op_ready == ce)
        else $error("ready differs from enable");
    chk_done_next: assert property (s_take |=> res_done)
        else $error("no completion pulse");
    chk_add_narrow: assert property (
        s_rr(AR_OP_ADD) |=> rd_wr_en && rd_wr_data == {8'h00, $past(sum16)})
        else $error("narrow sum wrong");
    chk_add_wide: assert property (
        s_rr(AR_OP_ADD_A) |=> rd_wr_en && rd_wr_data == $past(sum24))
        else $error("wide sum wrong");
    chk_cmp_nowrite: assert property (s_take ##0
        op_code inside {AR_OP_CMP, AR_OP_CMP_A, AR_OP_CMC} |=> !rd_wr_en)
        else $error("compare wrote register");
    chk_skip_carry: assert property (s_take ##0 (
        op_code <= AR_OP_CMC && op_src == AR_SRC_REG
        && op_dst == AR_DST_REG
        && ((op_cond == AR_COND_C && !flags[FLAG_C])
        || (op_cond == AR_COND_NC && flags[FLAG_C])))
        |=> res_skipped && !rd_wr_en)
        else $error("skipped op took effect");
    chk_sp_add: assert property (s_take ##0 (op_code == AR_OP_ADD_A
        && op_src == AR_SRC_REG && op_dst == AR_DST_SP)
        |=> sp_value == $past(sp_sum))
        else $error("stack pointer sum wrong");
    chk_store_pre: assert property (s_take ##0 (
        op_code == AR_OP_STORE && op_stk == AR_STK_PRE_DEC) |=> st_valid
        && st_addr == $past(sp_value) - 24'(STEP)
        && st_data == {8'h00, $past(rs_data)})
        else $error("pre-decrement store wrong");
    chk_freeze_ce: assert property (!ce |=> $stable({res_done, rd_wr_en,
        st_valid, sp_value, flags, st_addr}))
        else $error("state moved while clock enable low");
endmodule : ar_datapath_checker

bind ar_datapath ar_datapath_checker #(.STEP(STEP)) u_chk (
    .clk_sys, .rst, .ce, .op_valid, .op_ready, .op_code, .op_src, .op_dst,
    .op_cond, .op_stk, .rd_data, .rs_data, .res_done, .res_skipped,
    .rd_wr_en, .rd_wr_data, .sp_value, .flags, .st_valid, .st_addr,
    .st_data);

// ==== test/ar_regfile_model.sv ====
`timescale 1ns/10ps
module ar_regfile_model (
    input  wire logic        clk_sys,
    input  wire logic        ce,
    input  wire logic        op_valid,
    input  wire logic [2:0]  rd_idx,
    input  wire logic [2:0]  rs_idx,
    input  wire logic        rd_wr_en,
    input  wire logic [23:0] rd_wr_data,
    output logic      [23:0] rd_data,
    output logic      [23:0] rs_data
);
    logic [23:0] regs [8] = '{24'h000000, 24'h00ffff, 24'h007fff,
        24'h008000, 24'hffffff, 24'h7fffff, 24'h000001, 24'h123456};
    logic [2:0]  wr_idx = 3'h0;
    assign rd_data = regs[rd_idx];
    assign rs_data = regs[rs_idx];
    // write back lands where the taken op pointed
    always @(posedge clk_sys) begin
        if (rd_wr_en) regs[wr_idx] <= rd_wr_data;
        if (ce && op_valid) wr_idx <= rd_idx;
    end
endmodule : ar_regfile_model

// ==== test/ar_datapath_tb_top.sv ====
`timescale 1ns/10ps
module ar_datapath_tb_top;
    import ar_pkg::*;
    localparam int          STEP_T = 3;
    localparam logic [23:0] STEP_V = 24'h000003;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        op_valid = 1'b0;
    ar_op_type   op_code = AR_OP_ADD;
    ar_src_type  op_src = AR_SRC_REG;
    ar_dst_type  op_dst = AR_DST_REG;
    ar_cond_type op_cond = AR_COND_ALWAYS;
    ar_stk_type  op_stk = AR_STK_PLAIN;
    logic [6:0]  op_imm = 7'h00;
    logic [2:0]  rd_idx = 3'h0;
    logic [2:0]  rs_idx = 3'h0;
    logic [23:0] rd_data, rs_data, rd_wr_data, sp_value, st_addr;
    logic [31:0] st_data;
    logic [3:0]  flags;
    logic        op_ready, res_done, res_skipped, res_error, rd_wr_en;
    logic        st_valid;
    logic [23:0] m_sp = 24'h000000;
    logic [23:0] m_wd = 24'h000000;
    logic [23:0] m_sa = 24'h000000;
    logic [31:0] m_sd = 32'h00000000;
    logic [3:0]  m_fl = 4'h0;
    logic        m_wr, m_sk, m_er, m_sv;
    int          n_mismatch = 0;
    int          checked = 0;
    always #5 clk_sys = ~clk_sys;
    ar_datapath #(.STEP(STEP_T)) dut (.clk_sys, .rst, .ce, .op_valid,
        .op_ready, .op_code, .op_src, .op_dst, .op_cond, .op_stk, .rd_data,
        .rs_data, .op_imm, .res_done, .res_skipped, .res_error, .rd_wr_en,
        .rd_wr_data, .sp_value, .flags, .st_valid, .st_addr, .st_data);
    ar_regfile_model far (.clk_sys, .ce, .op_valid, .rd_idx, .rs_idx,
        .rd_wr_en, .rd_wr_data, .rd_data, .rs_data);
    task automatic model();
        logic [24:0] r;
        logic [23:0] a, b, m;
        logic        w, s, ci;
        int          h;
        w = op_code inside {AR_OP_ADD_A, AR_OP_SUB_A, AR_OP_CMP_A,
            AR_OP_LD_SP};
        m = w ? 24'hffffff : 24'h00ffff;
        h = w ? 23 : 15;
        s = op_code inside {AR_OP_SUB, AR_OP_SUB_A, AR_OP_SBC, AR_OP_CMP,
            AR_OP_CMP_A, AR_OP_CMC};
        ci = op_code inside {AR_OP_ADC, AR_OP_SBC, AR_OP_CMC} && m_fl[0];
        a = (op_dst == AR_DST_SP ? m_sp : rd_data) & m;
        b = op_src == AR_SRC_REG ? rs_data
            : {{17{op_imm[6] & op_src[1]}}, op_imm};
        b = b & m;
        r = s ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
        m_sk = op_src == AR_SRC_REG && op_dst == AR_DST_REG
            && op_code <= AR_OP_CMC && op_cond != AR_COND_ALWAYS
            && (op_cond == AR_COND_C) != m_fl[0];
        m_er = op_dst == AR_DST_SP
            && !(op_code inside {AR_OP_ADD_A, AR_OP_SUB_A});
        m_wr = 1'b0;
        m_sv = op_code == AR_OP_STORE;
        if (m_sv) begin
            m_sa = op_stk == AR_STK_PRE_DEC ? m_sp - STEP_V : m_sp;
            m_sd = {8'h00, rs_data};
            if (op_stk == AR_STK_POST_INC) m_sp = m_sp + STEP_V;
            else if (op_stk != AR_STK_PLAIN) m_sp = m_sp - STEP_V;
        end else if (op_code == AR_OP_LD_SP) begin
            m_sp = b;
        end else if (!m_sk && !m_er) begin
            if (op_dst == AR_DST_SP) m_sp = r[23:0];
            else if (!(op_code inside {AR_OP_CMP, AR_OP_CMP_A,
                    AR_OP_CMC})) begin
                m_wr = 1'b1;
                m_wd = r[23:0] & m;
            end
            m_fl = {r[h], (r[23:0] & m) == 24'h0, r[h] != a[h]
                && (s ? a[h] != b[h] : a[h] == b[h]), r[h + 1]};
        end
    endtask : model
    task automatic compare(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hd1351b6e));
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (400) begin
            @(negedge clk_sys);
            op_code = ar_op_type'($urandom_range(0, 10));
            op_src = ar_src_type'(op_code == AR_OP_STORE ? 0
                : $urandom_range(0, op_code == AR_OP_CMP ? 2 : 1));
            op_dst = ar_dst_type'(op_code < AR_OP_STORE
                && $urandom_range(0, 3) == 0);
            op_cond = ar_cond_type'($urandom_range(0, 2));
            op_stk = ar_stk_type'($urandom_range(0, 3));
            op_imm = 7'($urandom);
            rd_idx = 3'($urandom);
            rs_idx = 3'($urandom);
            op_valid = 1'b1;
            #1 model();
            @(negedge clk_sys);
            op_valid = 1'b0;
            // a frozen cycle must hold every pulse and value
            if ($urandom_range(0, 3) == 0) begin
                ce = 1'b0;
                @(negedge clk_sys);
                ce = 1'b1;
            end
            compare(rd_wr_data, m_wd);
            compare(rd_wr_en, m_wr);
            compare(flags, m_fl);
            compare({res_done, res_skipped}, {1'b1, m_sk});
            compare({res_error, sp_value}, {m_er, m_sp});
            compare({st_valid, st_addr}, {m_sv, m_sa});
            compare(st_data, m_sd);
        end
        complete_run();
    end
endmodule : ar_datapath_tb_top
